//--- src/arst_cfg.svh
// alarm reset input logic: offsets, fields, reset values and codes
// assumes a 32-bit apb register bus with word aligned registers
// What this block does
// - usage setting accepts only codes 1, 2, 3
// - code 1: clear on open-to-closed edge
// - code 1: already closed input needs reopen first
// - code 2: clear on closed-to-open edge
// - code 2: already open input needs reclose first
// - code 3: input ignored, left general purpose
// - clear edge clears faults and alarm word
// - enable variant code 1: enable on reopen
// - enable variant code 2: enable on reclose
// - speed-change command modes override usage setting
// - speed modes or enable config force code 3
// - enable config write of 1 or 2 takes input from reset
// - flexible parts: reset point is 2 or 4
// - flexible parts re-enable at idle only with enable config 0
// - standard parts ignore the point parameter
// - energized reads low/closed, open reads high
// - alarm word read at once, volatile, read-only
// - fault bits disable motor until cleared
`ifndef ARST_CFG_SVH
`define ARST_CFG_SVH
`define ARST_OFS_USAGE 8'h00
`define ARST_OFS_MODE 8'h04
`define ARST_OFS_DIR 8'h08
`define ARST_OFS_WORD 8'h0C
`define ARST_OFS_STAT 8'h10
`define ARST_USE_LSB 0
`define ARST_PT_LSB 4
`define ARST_CM_LSB 0
`define ARST_EN_LSB 8
`define ARST_USE_RST 2'h1
`define ARST_PT_RST 3'h4
`define ARST_PT_A 3'h2
`define ARST_PT_B 3'h4
`define ARST_STD_PT 3'h3
`define ARST_CM_S0 5'h0D
`define ARST_CM_S1 5'h0E
`define ARST_CM_S2 5'h11
`define ARST_CM_S3 5'h12
`define ARST_KIND_STD 2'h0
`define ARST_KIND_EN 2'h1
`define ARST_KIND_FLEX 2'h2
`endif

//--- src/arst_pkg.sv
// alarm reset input logic: shared types
// assumes arst_cfg.svh for the numeric codes
`default_nettype none
package arst_pkg;
  typedef enum logic [1:0] {
    ARST_USE_CLOSE = 2'h1,
    ARST_USE_OPEN = 2'h2,
    ARST_USE_GP = 2'h3
  } arst_usage_t;
  typedef enum logic [2:0] {
    ARST_ST_RUN = 3'b001,
    ARST_ST_FAULT = 3'b010,
    ARST_ST_WAIT = 3'b100
  } arst_state_t;
endpackage : arst_pkg
`default_nettype wire

//--- src/arst_top.sv
// alarm reset input logic: apb registers, input edge clear, drive enable
// assumes raw pins from outside the pclk domain, alarm sources on pclk
`include "arst_cfg.svh"
`default_nettype none
module arst_top #(
  parameter logic [1:0] IO_KIND = `ARST_KIND_STD,
  parameter int NPINS = 8,
  parameter logic [15:0] FAULT_MASK = 16'hFFFF
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // inputs: 1 open, 0 closed
  input wire logic [NPINS-1:0] in_level,
  // alarm sources, one-cycle pulses
  input wire logic [15:0] alarm_in,
  // drive side
  output logic drive_en,
  output logic clear_pulse,
  output logic [NPINS-1:0] gp_level,
  output arst_pkg::arst_usage_t usage_out
);
  import arst_pkg::*;

  logic [NPINS-1:0] sync1_reg;
  logic [NPINS-1:0] sync2_reg;
  logic [NPINS-1:0] gp_reg;
  arst_usage_t usage_reg;
  logic [2:0] point_reg;
  logic [4:0] cm_reg;
  logic [1:0] encfg_reg;
  logic [7:0] dir_reg;
  logic [15:0] word_reg;
  logic [15:0] word_next;
  logic lvl_prev_reg;
  logic clear_reg;
  logic drive_en_reg;
  arst_state_t state_reg;
  arst_state_t state_next;
  logic [31:0] prdata_reg;
  logic pready_reg;
  logic pslverr_reg;

  // bus decode
  wire setup = psel && !penable && !pready_reg;
  wire wr_done = psel && penable && pready_reg && pwrite;
  wire hit_usage = paddr == `ARST_OFS_USAGE;
  wire hit_mode = paddr == `ARST_OFS_MODE;
  wire hit_dir = paddr == `ARST_OFS_DIR;
  wire hit_word = paddr == `ARST_OFS_WORD;
  wire hit_stat = paddr == `ARST_OFS_STAT;
  wire mapped = hit_usage | hit_mode | hit_dir | hit_word | hit_stat;
  wire wr_usage = wr_done && hit_usage;
  wire wr_mode = wr_done && hit_mode;
  wire wr_dir = wr_done && hit_dir;

  // write field decode
  wire [1:0] w_use = pwdata[`ARST_USE_LSB+:2];
  wire [2:0] w_pt = pwdata[`ARST_PT_LSB+:3];
  wire [4:0] w_cm = pwdata[`ARST_CM_LSB+:5];
  wire [1:0] w_en = pwdata[`ARST_EN_LSB+:2];
  wire w_use_ok = w_use != 2'h0;
  wire w_pt_ok = IO_KIND == `ARST_KIND_FLEX &&
                 (w_pt == `ARST_PT_A || w_pt == `ARST_PT_B);
  wire w_cm_spd = w_cm == `ARST_CM_S0 || w_cm == `ARST_CM_S1 ||
                  w_cm == `ARST_CM_S2 || w_cm == `ARST_CM_S3;
  wire w_en_hw = w_en == 2'h1 || w_en == 2'h2;
  wire cm_spd = cm_reg == `ARST_CM_S0 || cm_reg == `ARST_CM_S1 ||
                cm_reg == `ARST_CM_S2 || cm_reg == `ARST_CM_S3;

  // selected input and its idle level
  wire [2:0] sel_pt = IO_KIND == `ARST_KIND_FLEX ? point_reg : `ARST_STD_PT;
  wire sel_lvl = sync2_reg[sel_pt];
  wire src_ok = IO_KIND != `ARST_KIND_FLEX || dir_reg[sel_pt];
  wire [1:0] use_eff = cm_spd ? ARST_USE_GP : usage_reg;
  wire idle_lvl = use_eff == ARST_USE_CLOSE;
  wire armed = use_eff != ARST_USE_GP && src_ok;
  // edge seen only from registered samples: an input already at trigger level
  // when an alarm arrives must first return to idle
  wire edge_hit = armed && lvl_prev_reg == idle_lvl &&
                  sel_lvl != idle_lvl;
  wire fault_new = |(alarm_in & FAULT_MASK);
  wire fault_held = |(word_next & FAULT_MASK);
  wire need_wait = IO_KIND == `ARST_KIND_EN ||
                   (IO_KIND == `ARST_KIND_FLEX && encfg_reg == 2'h0);

  // status and read mux
  wire [31:0] stat_word = {28'h0000000, state_reg == ARST_ST_WAIT,
                           sel_lvl, |(word_reg & FAULT_MASK), drive_en_reg};
  wire [31:0] rd_mux =
    hit_usage ? {25'h0000000, point_reg, 2'h0, usage_reg} :
    hit_mode ? {22'h000000, encfg_reg, 3'h0, cm_reg} :
    hit_dir ? {24'h000000, dir_reg} :
    hit_word ? {16'h0000, word_reg} :
    hit_stat ? stat_word : 32'h00000000;

  // a new alarm wins over a clear in the same cycle
  assign word_next = (clear_reg ? 16'h0000 : word_reg) | alarm_in;

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ARST_ST_RUN: begin
        if (fault_held) begin
          state_next = ARST_ST_FAULT;
        end
      end
      ARST_ST_FAULT: begin
        if (clear_reg && !fault_new) begin
          state_next = need_wait ? ARST_ST_WAIT : ARST_ST_RUN;
        end
      end
      ARST_ST_WAIT: begin
        if (fault_held) begin
          state_next = ARST_ST_FAULT;
        end else if (sel_lvl == idle_lvl || use_eff == ARST_USE_GP) begin
          state_next = ARST_ST_RUN;
        end
      end
      default: begin
        state_next = ARST_ST_FAULT;
      end
    endcase
  end

  // two-stage input synchroniser
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_reg <= '1;
      sync2_reg <= '1;
      gp_reg <= '1;
      lvl_prev_reg <= 1'b1;
    end else begin
      sync1_reg <= in_level;
      sync2_reg <= sync1_reg;
      gp_reg <= sync2_reg;
      lvl_prev_reg <= sel_lvl;
    end
  end

  // usage setting, claimed back by speed modes and enable config
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      usage_reg <= ARST_USE_CLOSE;
      point_reg <= `ARST_PT_RST;
    end else if (wr_mode && (w_cm_spd || w_en_hw)) begin
      usage_reg <= ARST_USE_GP;
    end else if (wr_usage) begin
      if (w_use_ok) begin
        usage_reg <= arst_usage_t'(w_use);
      end
      if (w_pt_ok) begin
        point_reg <= w_pt;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cm_reg <= 5'h00;
      encfg_reg <= 2'h0;
      dir_reg <= 8'h00;
    end else begin
      if (wr_mode) begin
        cm_reg <= w_cm;
        encfg_reg <= w_en;
      end
      if (wr_dir) begin
        dir_reg <= pwdata[7:0];
      end
    end
  end

  // clear pulse, alarm word and drive enable
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clear_reg <= 1'b0;
      word_reg <= 16'h0000;
      state_reg <= ARST_ST_RUN;
      drive_en_reg <= 1'b1;
    end else begin
      clear_reg <= edge_hit;
      word_reg <= word_next;
      state_reg <= state_next;
      drive_en_reg <= state_next == ARST_ST_RUN;
    end
  end

  // apb answer: data latched at setup, ready in the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= 32'h00000000;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
    end else begin
      pready_reg <= setup;
      pslverr_reg <= setup && !mapped;
      if (setup && !pwrite) begin
        prdata_reg <= rd_mux;
      end
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign drive_en = drive_en_reg;
  assign clear_pulse = clear_reg;
  assign gp_level = gp_reg;
  assign usage_out = usage_reg;

  a_usage_legal: assert property (
    @(posedge pclk) disable iff (!presetn)
    usage_reg != 2'h0)
    else $error("usage code left the legal set");

  a_close_clears: assert property (
    @(posedge pclk) disable iff (!presetn)
    (use_eff == ARST_USE_CLOSE && src_ok && lvl_prev_reg && !sel_lvl)
    |=> clear_reg)
    else $error("closing edge did not clear");

  a_open_clears: assert property (
    @(posedge pclk) disable iff (!presetn)
    (use_eff == ARST_USE_OPEN && src_ok && !lvl_prev_reg && sel_lvl)
    |=> clear_reg)
    else $error("opening edge did not clear");

  a_gp_no_clear: assert property (
    @(posedge pclk) disable iff (!presetn)
    use_eff == ARST_USE_GP |=> !clear_reg)
    else $error("clear while input is general purpose");

  a_clear_word: assert property (
    @(posedge pclk) disable iff (!presetn)
    (clear_reg && alarm_in == 16'h0000) |=> word_reg == 16'h0000)
    else $error("alarm word survived a clear");

  a_fault_stops: assert property (
    @(posedge pclk) disable iff (!presetn)
    fault_new |=> !drive_en_reg [*2])
    else $error("drive stayed enabled after a fault");

  a_reenable_idle: assert property (
    @(posedge pclk) disable iff (!presetn)
    (state_reg == ARST_ST_WAIT && !fault_held && sel_lvl == idle_lvl)
    |=> drive_en_reg)
    else $error("drive not re-enabled at idle level");

  a_speed_forces: assert property (
    @(posedge pclk) disable iff (!presetn)
    (wr_mode && w_cm_spd) |=> usage_reg == ARST_USE_GP)
    else $error("speed mode did not force code 3");

  a_single_pulse: assert property (
    @(posedge pclk) disable iff (!presetn)
    clear_reg |=> !clear_reg)
    else $error("clear pulse longer than one cycle");

  a_read_now: assert property (
    @(posedge pclk) disable iff (!presetn)
    (setup && !pwrite && hit_word) |=> (pready && prdata[15:0] == $past(word_reg)))
    else $error("alarm word not answered at once");

  a_use_refused: assert property (
    @(posedge pclk) disable iff (!presetn)
    (wr_usage && !w_use_ok) |=> $stable(usage_reg))
    else $error("illegal usage code was taken");

  a_close_holds: assert property (
    @(posedge pclk) disable iff (!presetn)
    (use_eff == ARST_USE_CLOSE && !lvl_prev_reg) |=> !clear_reg)
    else $error("clear without reopening first");

  a_open_holds: assert property (
    @(posedge pclk) disable iff (!presetn)
    (use_eff == ARST_USE_OPEN && lvl_prev_reg) |=> !clear_reg)
    else $error("clear without reclosing first");

  a_wait_hold: assert property (
    @(posedge pclk) disable iff (!presetn)
    (state_reg == ARST_ST_WAIT && use_eff != ARST_USE_GP && sel_lvl != idle_lvl)
    |=> !drive_en_reg)
    else $error("drive enabled before input returned to idle");

  a_speed_blocks: assert property (
    @(posedge pclk) disable iff (!presetn)
    cm_spd |=> !clear_reg)
    else $error("clear while a speed mode owns the input");

  a_encfg_claims: assert property (
    @(posedge pclk) disable iff (!presetn)
    (wr_mode && w_en_hw) |=> usage_reg == ARST_USE_GP)
    else $error("enable config did not take the input");

  a_point_legal: assert property (
    @(posedge pclk) disable iff (!presetn)
    point_reg == `ARST_PT_A || point_reg == `ARST_PT_B)
    else $error("reset point outside the legal set");

  a_point_input: assert property (
    @(posedge pclk) disable iff (!presetn)
    (IO_KIND == `ARST_KIND_FLEX && !dir_reg[point_reg]) |=> !clear_reg)
    else $error("clear from a point not set as input");

  a_hw_en_now: assert property (
    @(posedge pclk) disable iff (!presetn)
    (state_reg == ARST_ST_FAULT && clear_reg && !fault_new && !need_wait) |=> drive_en_reg)
    else $error("drive not enabled at once after clear");

  a_std_point: assert property (
    @(posedge pclk) disable iff (!presetn)
    IO_KIND != `ARST_KIND_FLEX |-> point_reg == `ARST_PT_RST)
    else $error("point parameter used on a standard part");

  a_alarm_sets: assert property (
    @(posedge pclk) disable iff (!presetn)
    alarm_in != 16'h0000 |=> (word_reg & $past(alarm_in)) == $past(alarm_in))
    else $error("alarm bit lost against a clear");

  a_pulse_edge: assert property (
    @(posedge pclk) disable iff (!presetn)
    clear_reg |-> $past(lvl_prev_reg) != $past(sel_lvl))
    else $error("clear pulse without an input edge");

  a_gp_follows: assert property (
    @(posedge pclk) disable iff (!presetn)
    gp_reg == $past(sync2_reg))
    else $error("general purpose level not following pins");

  a_fault_held: assert property (
    @(posedge pclk) disable iff (!presetn)
    state_reg == ARST_ST_FAULT |-> !drive_en_reg)
    else $error("drive enabled while a fault is latched");

endmodule : arst_top
`default_nettype wire

//--- testbench/arst_sw.sv
// switch model on the far side: one contact wired to pins 3 and 4
// assumes pins read 1 when open and 0 when the contact closes
`default_nettype none
module arst_sw (
  // contact state from the bench
  input wire logic closed,
  // input pins
  output logic [7:0] in_level
);
  timeunit 1ns;
  timeprecision 1ps;
  // unused pins are unconnected and read open
  assign in_level = {3'h7, ~closed, ~closed, 3'h7};
endmodule : arst_sw
`default_nettype wire

//--- testbench/test_alarm_reset_input_logic.sv
// self-checking bench for the alarm reset input logic
// assumes arst_top defaults: standard io on pin 3, plus enable and flexible variants
`include "arst_cfg.svh"
`default_nettype none
module test_alarm_reset_input_logic;
  timeunit 1ns;
  timeprecision 1ps;
  import arst_pkg::*;
  logic pclk = 1'h0;
  logic presetn = 1'h0;
  logic psel = 1'h0;
  logic penable = 1'h0;
  logic pwrite = 1'h0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic sw_closed = 1'h0;
  logic [7:0] in_level;
  logic [15:0] alarm_in = 16'h0;
  logic drive_en;
  logic clear_pulse;
  logic [7:0] gp_level;
  arst_usage_t usage_out;
  logic [31:0] rd;
  logic err;
  logic en_drive_en;
  logic fx_drive_en;
  logic [31:0] fx_prdata;
  logic [31:0] fx_rd;
  int failures = 0;
  int total_checks = 0;
  int modes [4] = '{13, 14, 17, 18};

  arst_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .in_level(in_level), .alarm_in(alarm_in), .drive_en(drive_en),
    .clear_pulse(clear_pulse), .gp_level(gp_level), .usage_out(usage_out));
  arst_sw partner (.closed(sw_closed), .in_level(in_level));
  // enable-input and flexible variants share the bus and pins
  arst_top #(.IO_KIND(`ARST_KIND_EN)) DUT_EN (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(),
    .pready(), .pslverr(), .in_level(in_level), .alarm_in(alarm_in),
    .drive_en(en_drive_en), .clear_pulse(), .gp_level(), .usage_out());
  arst_top #(.IO_KIND(`ARST_KIND_FLEX)) DUT_FX (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(fx_prdata),
    .pready(), .pslverr(), .in_level(in_level), .alarm_in(alarm_in),
    .drive_en(fx_drive_en), .clear_pulse(), .gp_level(), .usage_out());

  initial begin
    forever #4 pclk = ~pclk;
  end

  task automatic summarize();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : summarize

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t value %0h expected %0h", $time, got, exp);
    end
  endtask : chk

  task automatic chk1(input logic got, input logic exp);
    chk({31'h0, got}, {31'h0, exp});
  endtask : chk1

  // one apb transfer, entered just after a rising edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'h1 && n < 20);
    if (n >= 20) begin
      failures++;
      summarize();
    end
    rd = prdata;
    fx_rd = fx_prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    // idle edge: a following call never reassigns psel in this time step
    @(posedge pclk);
  endtask : apb

  task automatic alarm(input logic [15:0] v);
    alarm_in <= v;
    @(posedge pclk);
    alarm_in <= 16'h0;
    repeat (2) @(posedge pclk);
  endtask : alarm

  // move the contact, then look for a clear pulse within six edges
  task automatic sw(input logic c, input logic want);
    logic seen;
    seen = 1'h0;
    sw_closed <= c;
    repeat (6) begin
      @(posedge pclk);
      if (clear_pulse === 1'h1) seen = 1'h1;
    end
    chk1(seen, want);
  endtask : sw

  task automatic word(input logic [15:0] exp);
    apb(1'h0, `ARST_OFS_WORD, 32'h0);
    chk(rd, {16'h0, exp});
  endtask : word

  initial begin
    repeat (20000) @(posedge pclk);
    failures++;
    summarize();
  end

  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'h1;
    @(posedge pclk);
    apb(1'h0, `ARST_OFS_USAGE, 32'h0);
    chk(rd, 32'h41);
    chk1(drive_en, 1'h1);
    apb(1'h0, 8'h14, 32'h0);
    chk1(err, 1'h1);
    $display("test reset done");
    alarm(16'h0001);
    chk1(drive_en, 1'h0);
    apb(1'h1, `ARST_OFS_WORD, 32'h0);
    word(16'h0001);
    sw(1'h1, 1'h1);
    word(16'h0000);
    chk1(drive_en, 1'h1);
    sw(1'h0, 1'h0);
    sw(1'h1, 1'h1);
    alarm(16'h0001);
    word(16'h0001);
    sw(1'h0, 1'h0);
    sw(1'h1, 1'h1);
    word(16'h0000);
    $display("test code one done");
    apb(1'h1, `ARST_OFS_USAGE, 32'h2);
    chk({30'h0, usage_out}, 32'h2);
    alarm(16'h0002);
    sw(1'h0, 1'h1);
    word(16'h0000);
    sw(1'h1, 1'h0);
    sw(1'h0, 1'h1);
    alarm(16'h0002);
    word(16'h0002);
    sw(1'h1, 1'h0);
    sw(1'h0, 1'h1);
    word(16'h0000);
    apb(1'h1, `ARST_OFS_USAGE, 32'h0);
    chk({30'h0, usage_out}, 32'h2);
    $display("test code two done");
    apb(1'h1, `ARST_OFS_USAGE, 32'h3);
    alarm(16'h0004);
    sw(1'h1, 1'h0);
    chk1(gp_level[3], 1'h0);
    sw(1'h0, 1'h0);
    word(16'h0004);
    apb(1'h1, `ARST_OFS_USAGE, 32'h1);
    sw(1'h1, 1'h1);
    word(16'h0000);
    $display("test code three done");
    sw(1'h0, 1'h0);
    alarm(16'h0008);
    sw(1'h1, 1'h1);
    chk1(en_drive_en, 1'h0);
    sw(1'h0, 1'h0);
    chk1(en_drive_en, 1'h1);
    apb(1'h1, `ARST_OFS_USAGE, 32'h2);
    sw(1'h1, 1'h0);
    alarm(16'h0008);
    sw(1'h0, 1'h1);
    chk1(en_drive_en, 1'h0);
    sw(1'h1, 1'h0);
    chk1(en_drive_en, 1'h1);
    apb(1'h1, `ARST_OFS_USAGE, 32'h21);
    apb(1'h0, `ARST_OFS_USAGE, 32'h0);
    chk(rd, 32'h41);
    chk(fx_rd, 32'h21);
    apb(1'h1, `ARST_OFS_USAGE, 32'h31);
    apb(1'h0, `ARST_OFS_USAGE, 32'h0);
    chk(fx_rd, 32'h21);
    apb(1'h1, `ARST_OFS_USAGE, 32'h41);
    sw(1'h0, 1'h0);
    sw(1'h1, 1'h1);
    chk1(fx_drive_en, 1'h0);
    apb(1'h1, `ARST_OFS_DIR, 32'h10);
    sw(1'h0, 1'h0);
    sw(1'h1, 1'h1);
    chk1(fx_drive_en, 1'h0);
    sw(1'h0, 1'h0);
    chk1(fx_drive_en, 1'h1);
    apb(1'h1, `ARST_OFS_MODE, 32'h100);
    chk({30'h0, usage_out}, 32'h3);
    apb(1'h1, `ARST_OFS_USAGE, 32'h41);
    alarm(16'h0008);
    sw(1'h1, 1'h1);
    chk1(fx_drive_en, 1'h1);
    apb(1'h1, `ARST_OFS_MODE, 32'hD);
    apb(1'h1, `ARST_OFS_USAGE, 32'h41);
    alarm(16'h0008);
    sw(1'h0, 1'h0);
    sw(1'h1, 1'h0);
    word(16'h0008);
    apb(1'h1, `ARST_OFS_MODE, 32'h0);
    $display("test variants done");
    foreach (modes[i]) begin
      apb(1'h1, `ARST_OFS_MODE, modes[i]);
      chk({30'h0, usage_out}, 32'h3);
      apb(1'h1, `ARST_OFS_MODE, 32'h0);
      apb(1'h1, `ARST_OFS_USAGE, 32'h1);
    end
    apb(1'h1, `ARST_OFS_MODE, 32'h100);
    chk({30'h0, usage_out}, 32'h3);
    $display("test ownership done");
    summarize();
  end
endmodule : test_alarm_reset_input_logic
`default_nettype wire
